//--- logic/sdm_dev.sv
// memory access slave: decodes serial commands and commits them on the system clock
// What this block does
// - slave only; output on rising, input on falling
// - write commits after chip select goes high
// - chip select high resets port, output released
// - every byte shifted most significant bit first
// - ignore commands unless cpu held in reset, except the cpu reset test register
// - command byte plus one, two or three bytes
// - command bits 12:10 select the target memory
// - bit 9 direction, bit 8 odd parity
// - nonzero bits 15:13 rejected with failure flag, except for the register file
// - otp and prototype ram use four bytes
// - read data returns in the next transfer
// - check byte leads every transfer
// - check byte layout, low bits 010
// - only 16, 24 or 32 clocks accepted
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module sdm_dev (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  sdm_link_if.dev          LINK,
  input  wire logic        CPU_IN_RESET,
  output logic             MEM_REQ,
  output logic             MEM_WRITE,
  output logic      [2:0]  MEM_TARGET,
  output logic      [15:0] MEM_ADDR,
  output logic      [7:0]  MEM_WDATA,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic        MEM_ACK,
  output logic      [7:0]  LAST_CHECK
);
  typedef struct packed {
    logic        cs_d;
    logic        sclk_d;
    logic [31:0] rx;
    logic [5:0]  nfall;
    logic [5:0]  nrise;
    logic        out;
    logic [7:0]  check;
    logic [7:0]  rdata;
    logic        req;
    logic        we;
    logic [2:0]  tgt;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sdm_dev_t;

  sdm_dev_t s, next_s;
  logic [2:0] pins;
  logic       cs_f;
  logic       sclk_f;
  logic       din_f;

  // cs, sclk and data arrive from another domain
  sdm_sync3 #(.W(3), .INIT(sdm_pkg::DEV_PIN_RST)) u_sync (
    .CLK    (CLK),
    .RESETN (RESETN),
    .PIN    ({LINK.serial_in_line, LINK.sclk, LINK.cs_n}),
    .LEVEL  (pins)
  );

  assign cs_f   = pins[0];
  assign sclk_f = pins[1];
  assign din_f  = pins[2];

  // decode of the finished transfer and next state
  always_comb begin
    logic        fall;
    logic        rise;
    logic        done;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [2:0]  up;
    logic [2:0]  tgt;
    logic [5:0]  need;
    logic        e_par;
    logic        e_addr;
    logic        e_cmd;
    logic        e_clk;
    logic        blocked;
    logic [31:0] stream;
    fall    = 1'b0;
    rise    = 1'b0;
    done    = 1'b0;
    cmd     = 8'h00;
    addr    = 16'h0000;
    data    = 8'h00;
    up      = 3'h0;
    tgt     = 3'h0;
    need    = sdm_pkg::LEN24;
    e_par   = 1'b0;
    e_addr  = 1'b0;
    e_cmd   = 1'b0;
    e_clk   = 1'b0;
    blocked = 1'b0;
    stream  = 32'h0000_0000;
    next_s  = s;

    next_s.cs_d   = cs_f;
    next_s.sclk_d = sclk_f;
    fall = !cs_f && s.sclk_d && !sclk_f;
    rise = !cs_f && !s.sclk_d && sclk_f;
    done = cs_f && !s.cs_d;

    // sample input on falling edge, msb first
    if (fall) begin
      next_s.rx = {s.rx[30:0], din_f};
      if (s.nfall != 6'h3f) begin
        next_s.nfall = s.nfall + 6'h01;
      end
    end

    // check byte, then data of the last read
    stream = {s.check, s.rdata, 16'h0000};
    if (rise) begin
      next_s.out = s.nrise[5] ? 1'b0 : stream[5'd31 - s.nrise[4:0]];
      if (s.nrise != 6'h3f) begin
        next_s.nrise = s.nrise + 6'h01;
      end
    end

    // locate fields from the clock count
    unique case (s.nfall)
      sdm_pkg::LEN16: begin
        cmd  = s.rx[15:8];
        data = s.rx[7:0];
      end
      sdm_pkg::LEN24: begin
        cmd  = s.rx[23:16];
        addr = {8'h00, s.rx[15:8]};
        data = s.rx[7:0];
      end
      sdm_pkg::LEN32: begin
        cmd  = s.rx[31:24];
        addr = s.rx[23:8];
        data = s.rx[7:0];
      end
      default: begin
        cmd   = 8'h00;
        e_clk = 1'b1;
      end
    endcase

    up  = cmd[sdm_pkg::CMD_UP_LSB +: 3];
    tgt = cmd[sdm_pkg::CMD_TGT_LSB +: 3];
    // register file address sits in the upper bits
    if (tgt == sdm_pkg::TGT_REG) begin
      addr = {13'h0000, up};
    end
    // long targets need four bytes, register file two
    if (tgt == sdm_pkg::TGT_OTP || tgt == sdm_pkg::TGT_PROTO) begin
      need = sdm_pkg::LEN32;
    end else if (tgt == sdm_pkg::TGT_REG) begin
      need = sdm_pkg::LEN16;
    end else begin
      need = sdm_pkg::LEN24;
    end
    // odd parity over bits 15:8 including the parity bit
    e_par  = !e_clk && !(^cmd);
    // upper bits must be clear for a memory target
    e_addr = !e_clk && up != 3'h0 && tgt != sdm_pkg::TGT_REG;
    e_cmd  = !e_clk && ((up == 3'h0 && tgt == sdm_pkg::TGT_REG) || s.nfall != need);

    // only the cpu reset register is reachable while it runs
    blocked = !CPU_IN_RESET &&
              !(tgt == sdm_pkg::TGT_TEST && addr == sdm_pkg::MICRO_RESET_ADDR);

    // finished request leaves once the memory side takes it
    if (s.req && MEM_ACK) begin
      next_s.req = 1'b0;
      if (!s.we) begin
        next_s.rdata = MEM_RDATA;
      end
    end

    if (done && !blocked) begin
      // status of this transfer for the next check byte
      next_s.check[sdm_pkg::CHK_PAR]  = e_par;
      next_s.check[sdm_pkg::CHK_ADDR] = e_addr;
      next_s.check[sdm_pkg::CHK_CMD]  = e_cmd;
      next_s.check[sdm_pkg::CHK_CLK]  = e_clk;
      next_s.check[sdm_pkg::CHK_FAIL] = e_par | e_addr | e_cmd | e_clk;
      next_s.check[2:0]               = sdm_pkg::CHK_FIXED;
      // commit only a clean command, after cs rises
      if (!(e_par | e_addr | e_cmd | e_clk)) begin
        next_s.req   = 1'b1;
        next_s.we    = cmd[sdm_pkg::CMD_RW];
        next_s.tgt   = tgt;
        next_s.addr  = addr;
        next_s.wdata = data;
      end
    end

    // chip select high clears the shift state
    if (cs_f) begin
      next_s.rx    = 32'h0000_0000;
      next_s.nfall = 6'h00;
      next_s.nrise = 6'h00;
      next_s.out   = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s       <= '0;
      s.cs_d  <= 1'b1;
      s.check <= sdm_pkg::CHK_RST;
    end else begin
      s <= next_s;
    end
  end

  // output released whenever chip select is high
  assign LINK.serial_out_oe   = !cs_f;
  assign LINK.serial_out_line = s.out;
  assign MEM_REQ    = s.req;
  assign MEM_WRITE  = s.we;
  assign MEM_TARGET = s.tgt;
  assign MEM_ADDR   = s.addr;
  assign MEM_WDATA  = s.wdata;
  assign LAST_CHECK = s.check;
endmodule // sdm_dev

//--- logic/sdm_host.sv
// debug master: apb registers drive serial transfers on the link
`timescale 1ns/100ps
module sdm_host (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  sdm_link_if.host         LINK
);
  typedef struct packed {
    sdm_pkg::sdm_hstate_t st;
    logic [7:0]  tmr;
    logic [5:0]  left;
    logic [5:0]  len;
    logic        autopar;
    logic [31:0] txd;
    logic [31:0] sh;
    logic [31:0] rxd;
    logic [1:0]  isr;
    logic [1:0]  imr;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic [31:0] prdata;
    logic        slverr;
  } sdm_host_t;

  sdm_host_t s, next_s;
  logic      miso;

  // returned data comes from another domain
  sdm_sync3 #(.W(1), .INIT(sdm_pkg::HOST_PIN_RST)) u_sync (
    .CLK    (CLK),
    .RESETN (RESETN),
    .PIN    (LINK.serial_out_level),
    .LEVEL  (miso)
  );

  always_comb begin
    logic        wr;
    logic        setup;
    logic        hit;
    logic [1:0]  ev;
    logic [31:0] tx;
    logic [7:0]  chk;
    wr     = PSEL && PENABLE && PWRITE;
    setup  = PSEL && !PENABLE;
    hit    = 1'b1;
    ev     = 2'h0;
    tx     = s.txd;
    chk    = 8'h00;
    next_s = s;

    // odd parity over the whole upper command bits
    tx[24] = s.autopar ? ~^s.txd[31:25] : s.txd[24];

    // serial engine, paced by a half period timer
    if (s.tmr != 8'h00) begin
      next_s.tmr = s.tmr - 8'h01;
    end else begin
      unique case (s.st)
        sdm_pkg::H_IDLE: begin
        end
        sdm_pkg::H_LEAD: begin
          next_s.st = sdm_pkg::H_HI;
        end
        // master changes data on rising, msb first
        sdm_pkg::H_HI: begin
          next_s.sclk = 1'b1;
          next_s.mosi = s.sh[31];
          next_s.sh   = {s.sh[30:0], 1'b0};
          next_s.tmr  = sdm_pkg::SCLK_HALF;
          next_s.st   = sdm_pkg::H_LO;
        end
        sdm_pkg::H_LO: begin
          next_s.sclk = 1'b0;
          next_s.rxd  = {s.rxd[30:0], miso};
          next_s.left = s.left - 6'h01;
          next_s.tmr  = sdm_pkg::SCLK_HALF;
          next_s.st   = (s.left == 6'h01) ? sdm_pkg::H_TAIL : sdm_pkg::H_HI;
        end
        // chip select back high between transfers
        sdm_pkg::H_TAIL: begin
          next_s.cs_n = 1'b1;
          next_s.mosi = 1'b0;
          next_s.tmr  = sdm_pkg::CS_GAP;
          next_s.st   = sdm_pkg::H_GAP;
        end
        sdm_pkg::H_GAP: begin
          chk        = 8'(s.rxd >> (s.len - 6'h08));
          ev         = {chk[7], 1'b1};
          next_s.st  = sdm_pkg::H_IDLE;
        end
      endcase
    end

    // apb writes; a start is refused while busy
    if (wr) begin
      unique case (PADDR)
        sdm_pkg::A_CTRL: begin
          next_s.len     = PWDATA[5:0];
          next_s.autopar = PWDATA[sdm_pkg::CTRL_AUTOPAR];
          if (PWDATA[sdm_pkg::CTRL_GO] && s.st == sdm_pkg::H_IDLE && PWDATA[5:0] != 6'h00) begin
            next_s.st   = sdm_pkg::H_LEAD;
            next_s.cs_n = 1'b0;
            next_s.left = PWDATA[5:0];
            next_s.sh   = PWDATA[sdm_pkg::CTRL_AUTOPAR] ? {tx[31:25], ~^tx[31:25], tx[23:0]} : s.txd;
            next_s.rxd  = 32'h0000_0000;
            next_s.tmr  = sdm_pkg::SCLK_HALF;
          end
        end
        sdm_pkg::A_TXD: next_s.txd = PWDATA;
        sdm_pkg::A_ISR: next_s.isr = s.isr & ~PWDATA[1:0];
        sdm_pkg::A_IMR: next_s.imr = PWDATA[1:0];
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    next_s.isr = next_s.isr | ev;

    // read data captured in the setup cycle
    if (setup) begin
      unique case (PADDR)
        sdm_pkg::A_CTRL: next_s.prdata = {22'h0, s.autopar, 3'h0, s.len};
        sdm_pkg::A_TXD:  next_s.prdata = s.txd;
        sdm_pkg::A_RXD:  next_s.prdata = s.rxd;
        sdm_pkg::A_STAT: next_s.prdata = {31'h0, s.st != sdm_pkg::H_IDLE};
        sdm_pkg::A_ISR:  next_s.prdata = {30'h0, s.isr};
        sdm_pkg::A_IMR:  next_s.prdata = {30'h0, s.imr};
        default: begin
          next_s.prdata = 32'h0000_0000;
          hit           = 1'b0;
        end
      endcase
      next_s.slverr = !hit;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s      <= '0;
      s.st   <= sdm_pkg::H_IDLE;
      s.cs_n <= 1'b1;
      s.len  <= sdm_pkg::CTRL_LEN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA              = s.prdata;
  assign PREADY              = 1'b1;
  assign PSLVERR             = PSEL && PENABLE && s.slverr;
  assign IRQ                 = |(s.isr & s.imr);
  assign LINK.cs_n           = s.cs_n;
  assign LINK.sclk           = s.sclk;
  assign LINK.serial_in_line = s.mosi;
endmodule // sdm_host

//--- logic/sdm_link_if.sv
// four-wire link between the debug master and the memory access slave
`timescale 1ns/100ps
interface sdm_link_if;
  logic cs_n;
  logic sclk;
  logic serial_in_line;
  logic serial_out_line;
  logic serial_out_oe;
  logic serial_out_level;

  // released output floats high through a pull-up
  assign serial_out_level = serial_out_oe ? serial_out_line : 1'b1;

  modport dev  (input cs_n, sclk, serial_in_line, output serial_out_line, serial_out_oe);
  modport host (output cs_n, sclk, serial_in_line, input serial_out_level);
endinterface

//--- logic/sdm_pkg.sv
// constants, field positions and types shared by both ends of the debug memory link
package sdm_pkg;
  // system clock
  localparam int CLK_NS = 4;

  // target select codes in the command byte
  localparam logic [2:0] TGT_REG   = 3'h0;
  localparam logic [2:0] TGT_OTP   = 3'h1;
  localparam logic [2:0] TGT_FIFO  = 3'h2;
  localparam logic [2:0] TGT_EEP   = 3'h3;
  localparam logic [2:0] TGT_INTERNAL_DATA_RAM  = 3'h4;
  localparam logic [2:0] TGT_TEST  = 3'h5;
  localparam logic [2:0] TGT_EXTENDED_SPECIAL_FUNCTION_REGS  = 3'h6;
  localparam logic [2:0] TGT_PROTO = 3'h7;

  // field positions inside the command byte
  localparam int CMD_UP_LSB  = 5;
  localparam int CMD_TGT_LSB = 2;
  localparam int CMD_RW      = 1;
  localparam int CMD_PAR     = 0;

  // test register that holds the embedded cpu in reset
  localparam logic [15:0] MICRO_RESET_ADDR = 16'h0000;

  // check byte layout
  localparam int         CHK_FAIL  = 7;
  localparam int         CHK_PAR   = 6;
  localparam int         CHK_ADDR  = 5;
  localparam int         CHK_CMD   = 4;
  localparam int         CHK_CLK   = 3;
  localparam logic [2:0] CHK_FIXED = 3'h2;
  localparam logic [7:0] CHK_RST   = 8'h02;

  // legal serial clock counts per transfer
  localparam logic [5:0] LEN16 = 6'h10;
  localparam logic [5:0] LEN24 = 6'h18;
  localparam logic [5:0] LEN32 = 6'h20;

  // reset values of synchronised pins, order {data, sclk, cs}
  localparam logic [2:0] DEV_PIN_RST = 3'h1;
  localparam logic [0:0] HOST_PIN_RST = 1'h1;

  // host serial clock half period and gap with chip select high
  localparam int         SCLK_HALF_NS = 64;
  localparam logic [7:0] SCLK_HALF    = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam int         CS_GAP_NS    = 128;
  localparam logic [7:0] CS_GAP       = 8'((CS_GAP_NS + CLK_NS - 1) / CLK_NS);

  // host apb register offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_TXD  = 12'h004;
  localparam logic [11:0] A_RXD  = 12'h008;
  localparam logic [11:0] A_STAT = 12'h00c;
  localparam logic [11:0] A_ISR  = 12'h010;
  localparam logic [11:0] A_IMR  = 12'h014;

  // host control and interrupt bits
  localparam int         CTRL_GO      = 8;
  localparam int         CTRL_AUTOPAR = 9;
  localparam int         IRQ_DONE     = 0;
  localparam int         IRQ_CHKFAIL  = 1;
  localparam logic [5:0] CTRL_LEN_RST = 6'h18;

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HI, H_LO, H_TAIL, H_GAP} sdm_hstate_t;
endpackage

//--- logic/sdm_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module sdm_sync3 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         CLK,
  input  wire logic         RESETN,
  input  wire logic [W-1:0] PIN,
  output logic      [W-1:0] LEVEL
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } sdm_sync_t;

  sdm_sync_t s, next_s;

  // a bit only moves once stages two and three agree
  always_comb begin
    next_s    = s;
    next_s.s1 = PIN;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.f  = (s.s2 & ~(s.s2 ^ s.s3)) | (s.f & (s.s2 ^ s.s3));
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s <= '{s1: INIT, s2: INIT, s3: INIT, f: INIT};
    end else begin
      s <= next_s;
    end
  end

  assign LEVEL = s.f;
endmodule // sdm_sync3

//--- tb/sdm_link_checker.sv
// assertions on the debug link wires and the slave's memory port
`timescale 1ns/100ps
module sdm_link_checker (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       serial_in_line,
  input wire logic       serial_out_oe,
  input wire logic       serial_out_level,
  input wire logic       MEM_REQ,
  input wire logic       MEM_ACK,
  input wire logic [7:0] LAST_CHECK
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  // the slave sees the pins through a 3-stage sync, so allow a few cycles
  chk_release_idle: assert property (cs_n [*6] |-> !serial_out_oe)
    else $error("serial output driven while deselected");
  chk_drive_sel: assert property (!cs_n [*6] |-> serial_out_oe)
    else $error("serial output not driven while selected");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock active while deselected");
  // commit only once chip select has been high for a while
  chk_commit_late: assert property ($rose(MEM_REQ) |-> cs_n && $past(cs_n, 3))
    else $error("memory request before chip select rose");
  chk_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ)
    else $error("memory request dropped without ack");
  chk_req_drop: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
    else $error("memory request held after ack");
  // status may only move after a transfer closes
  chk_check_steady: assert property (!cs_n [*5] |-> $stable(LAST_CHECK))
    else $error("check byte changed inside a transfer");
  chk_check_low: assert property (LAST_CHECK[2:0] == 3'h2)
    else $error("check byte low bits wrong");
  chk_fail_flag: assert property (LAST_CHECK[7] == (|LAST_CHECK[6:3]))
    else $error("failure bit disagrees with cause bits");
  // master data moves only with a rising serial clock
  chk_mosi_rise: assert property ($changed(serial_in_line) && !cs_n |-> sclk)
    else $error("master data changed off the rising clock");
  chk_out_steady: assert property ((!sclk && !cs_n) [*8] |-> $stable(serial_out_level))
    else $error("slave data changed while clock low");

  cover property (MEM_REQ && MEM_ACK);
  cover property (LAST_CHECK[7]);
  cover property ($rose(cs_n));
endmodule // sdm_link_checker

//--- tb/tb_top.sv
// bench: host and slave joined over the link, apb and memory port driven here
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [5:0]  len;
    logic [31:0] tx;
    logic        req;
    logic [27:0] cap;
    logic [7:0]  chk;
  } sdm_row_t;

  logic        CLK          = 1'b0;
  logic        RESETN       = 1'b0;
  logic        PSEL         = 1'b0;
  logic        PENABLE      = 1'b0;
  logic        PWRITE       = 1'b0;
  logic [11:0] PADDR        = 12'h000;
  logic [31:0] PWDATA       = 32'h0;
  logic        CPU_IN_RESET = 1'b1;
  logic [7:0]  MEM_RDATA    = 8'h00;
  logic        MEM_ACK      = 1'b0;
  logic [31:0] PRDATA, rx, d, mi_sh, so_sh;
  logic        PREADY, PSLVERR, IRQ, MEM_REQ, MEM_WRITE, perr, hrd, sclk_d, cs_d;
  logic [2:0]  MEM_TARGET;
  logic [15:0] MEM_ADDR;
  logic [7:0]  MEM_WDATA, LAST_CHECK, pchk, rd;
  logic [27:0] cap;
  int          got = 0, falls = 0, n0, error_cnt = 0, check_count = 0;
  sdm_row_t    rows [14];
  sdm_row_t    r;

  always #2 CLK = ~CLK;

  sdm_link_if link ();
  sdm_host u_sdm_host (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .LINK(link));
  sdm_dev u_sdm_dev (.CLK(CLK), .RESETN(RESETN), .LINK(link), .CPU_IN_RESET(CPU_IN_RESET),
    .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_TARGET(MEM_TARGET), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .LAST_CHECK(LAST_CHECK));
  sdm_link_checker u_sdm_link_checker (.CLK(CLK), .RESETN(RESETN), .cs_n(link.cs_n), .sclk(link.sclk),
    .serial_in_line(link.serial_in_line), .serial_out_oe(link.serial_out_oe),
    .serial_out_level(link.serial_out_level), .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK),
    .LAST_CHECK(LAST_CHECK));

  // memory stand-in: acks one cycle late, read data is the address low byte xor 5a
  always @(posedge CLK) begin
    MEM_ACK <= MEM_REQ && !MEM_ACK;
    MEM_RDATA <= MEM_ADDR[7:0] ^ 8'h5a;
    if (MEM_REQ && !MEM_ACK) begin
      got <= got + 1;
      cap <= {MEM_WRITE, MEM_TARGET, MEM_ADDR, MEM_WDATA};
    end
  end

  // wire monitor: both data lines taken at each falling serial clock
  always @(posedge CLK) begin
    sclk_d <= link.sclk;
    cs_d <= link.cs_n;
    if (cs_d && !link.cs_n) begin
      falls <= 0;
      mi_sh <= 32'h0;
      so_sh <= 32'h0;
    end else if (!link.cs_n && sclk_d && !link.sclk) begin
      falls <= falls + 1;
      mi_sh <= {mi_sh[30:0], link.serial_in_line};
      so_sh <= {so_sh[30:0], link.serial_out_level};
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; starts on a fresh edge so release and setup never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    for (int n = 0; PREADY !== 1'b1; n++) begin
      if (n == 50) begin
        error_cnt++;
        complete_run();
      end
      @(posedge CLK);
    end
    q = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // load, start, poll busy under a bound, fetch received bits
  task automatic xfer(input logic [5:0] len, input logic [31:0] tx, input logic ap);
    logic [31:0] s;
    apb(1'b1, sdm_pkg::A_TXD, tx, s);
    apb(1'b1, sdm_pkg::A_CTRL, 32'h100 | (32'(ap) << sdm_pkg::CTRL_AUTOPAR) | 32'(len), s);
    s = 32'h1;
    for (int n = 0; n < 4000 && s[0] !== 1'b0; n++)
      apb(1'b0, sdm_pkg::A_STAT, 32'h0, s);
    if (s[0] !== 1'b0) begin
      error_cnt++;
      complete_run();
    end
    apb(1'b0, sdm_pkg::A_RXD, 32'h0, rx);
  endtask

  initial begin
    // len, bits sent, commit expected, {write, target, address, data}, resulting check byte
    rows[0] = '{6'h18, 32'h137f3400, 1'b1, 28'hc007f34, 8'h02};
    rows[1] = '{6'h18, 32'h10100000, 1'b1, 28'h4001000, 8'h02};
    rows[2] = '{6'h18, 32'h19c00000, 1'b1, 28'h600c000, 8'h02};
    rows[3] = '{6'h18, 32'h0e1fa500, 1'b1, 28'hb001fa5, 8'h02};
    rows[4] = '{6'h18, 32'h0b336600, 1'b1, 28'ha003366, 8'h02};
    rows[5] = '{6'h18, 32'h15070000, 1'b1, 28'h5000700, 8'h02};
    rows[6] = '{6'h20, 32'h071765d9, 1'b1, 28'h91765d9, 8'h02};
    rows[7] = '{6'h20, 32'h1c1c0000, 1'b1, 28'h71c0000, 8'h02};
    rows[8] = '{6'h10, 32'h23c80000, 1'b1, 28'h80001c8, 8'h02};
    rows[9] = '{6'h10, 32'h22c80000, 1'b0, 28'h0, 8'hc2};
    rows[10] = '{6'h20, 32'h26000000, 1'b0, 28'h0, 8'ha2};
    rows[11] = '{6'h18, 32'h1f7f3400, 1'b0, 28'h0, 8'h92};
    rows[12] = '{6'h14, 32'h137f3000, 1'b0, 28'h0, 8'h8a};
    rows[13] = '{6'h18, 32'h1ac13c00, 1'b1, 28'he00c13c, 8'h02};
    hrd = 1'b0;
    pchk = 8'h02;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    check(LAST_CHECK, 8'h02);
    check({link.cs_n, link.sclk, link.serial_out_oe}, 3'h4);
    apb(1'b0, sdm_pkg::A_CTRL, 32'h0, d);
    check(d, 32'h18);
    for (int i = 0; i < 14; i++) begin
      r = rows[i];
      n0 = got;
      xfer(r.len, r.tx, 1'b0);
      check(rx[r.len - 8 +: 8], pchk);
      if (hrd) check(rx[r.len - 16 +: 8], rd);
      check(mi_sh, r.tx >> (32 - r.len));
      check(so_sh, rx);
      check(falls, 32'(r.len));
      check(LAST_CHECK, r.chk);
      check(got - n0, 32'(r.req));
      if (r.req) check(cap[27:8], r.cap[27:8]);
      if (r.req && r.cap[27]) check(cap[7:0], r.cap[7:0]);
      if (r.req && !r.cap[27]) begin
        rd = r.cap[15:8] ^ 8'h5a;
        hrd = 1'b1;
      end
      pchk = r.chk;
    end
    // host fills in the parity bit of a register command handed over without it
    xfer(6'h10, 32'h22c80000, 1'b1);
    check(mi_sh, 32'h23c8);
    check(LAST_CHECK, 8'h02);
    check(cap, 28'h80001c8);
    // interrupt: sticky done, unmask, clear by writing one, masked event
    apb(1'b1, sdm_pkg::A_IMR, 32'h1, d);
    #1 check(IRQ, 1'b1);
    apb(1'b1, sdm_pkg::A_ISR, 32'h3, d);
    #1 check(IRQ, 1'b0);
    apb(1'b1, sdm_pkg::A_IMR, 32'h0, d);
    xfer(6'h18, 32'h137f3400, 1'b0);
    #1 check(IRQ, 1'b0);
    apb(1'b0, sdm_pkg::A_ISR, 32'h0, d);
    check(d[0], 1'b1);
    apb(1'b1, sdm_pkg::A_IMR, 32'h1, d);
    #1 check(IRQ, 1'b1);
    apb(1'b1, sdm_pkg::A_ISR, 32'h1, d);
    #1 check(IRQ, 1'b0);
    // unmapped offset reads zero with an error response
    apb(1'b0, 12'h100, 32'h0, d);
    check(perr, 1'b1);
    check(d, 32'h0);
    // cpu running: only the hold-reset test register answers, status kept
    xfer(6'h10, 32'h22c80000, 1'b0);
    CPU_IN_RESET <= 1'b0;
    n0 = got;
    xfer(6'h18, 32'h137f3400, 1'b0);
    check(got - n0, 32'h0);
    check(LAST_CHECK, 8'hc2);
    xfer(6'h18, 32'h16000100, 1'b0);
    check(got - n0, 32'h1);
    check(cap, 28'hd000001);
    CPU_IN_RESET <= 1'b1;
    // reset in mid-transfer: link released, nothing committed afterwards
    apb(1'b1, sdm_pkg::A_TXD, 32'h137f3400, d);
    apb(1'b1, sdm_pkg::A_CTRL, 32'h118, d);
    repeat (200) @(posedge CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    check({link.cs_n, link.sclk, link.serial_out_oe, MEM_REQ, LAST_CHECK}, 12'h802);
    RESETN <= 1'b1;
    n0 = got;
    repeat (40) @(posedge CLK);
    check(got - n0, 32'h0);
    complete_run();
  end
endmodule // tb_top
